/* lat_align_chk.sv */
// Port-level checks for the latency alignment block
`timescale 1ns/1ps
module lat_align_chk
	import lat_align_pkg::*;
#(
	parameter int PIPE_LEN = PIPE_DELAY
) (
	input wire logic        core_clk,      // Device clock
	input wire logic        sys_rst,       // Sync reset
	input wire logic        pclk_ce,       // Processing enable
	input wire logic        sysref_in,     // Reference pin
	input wire logic        deframe_valid, // Sample offered
	input wire logic        deframe_ready, // FIFO space
	input wire logic        dp_valid,      // Sample out
	input wire logic        lmfc_pulse,    // Multiframe edge
	input wire logic        psel,          // APB select
	input wire logic        penable,       // APB enable
	input wire logic        pwrite,        // APB write
	input wire logic [11:0] paddr,         // APB address
	input wire logic [31:0] pwdata,        // APB write data
	input wire logic        pready,        // APB ready
	input wire logic        pslverr        // APB error
);
	logic        sub1;
	logic [5:0]  lcnt;
	logic [15:0] nin, nout;
	wire         acc = psel && penable && pready;
	wire         mapped = paddr inside {ADDR_PHASE_A, ADDR_PHASE_B, ADDR_CTRL, ADDR_STATUS, ADDR_LATENCY};
	// Shadow of subclass bit, multiframe gap and sample counts
	always_ff @(posedge core_clk) begin
		sub1 <= sys_rst ? CTRL_RESET[CTRL_SUBCLASS1] : (acc && pwrite && paddr == ADDR_CTRL) ? pwdata[0] : sub1;
		lcnt <= (sys_rst || lmfc_pulse) ? 6'h00 : lcnt + 6'h01;
		nin <= sys_rst ? 16'h0000 : nin + {15'h0, deframe_valid && deframe_ready};
		nout <= sys_rst ? 16'h0000 : nout + {15'h0, dp_valid};
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	property p_zero_wait; psel && penable |-> pready; endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("access without ready");
	property p_unmapped; psel && penable && !mapped |-> pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_mapped_ok; psel && penable && mapped && !pwrite |-> !pslverr; endproperty
	a_mapped_ok: assert property (p_mapped_ok) else $error("mapped read refused");
	property p_sysref_lmfc; $rose(sysref_in) && sub1 |-> ##[8:11] lmfc_pulse; endproperty
	a_sysref_lmfc: assert property (p_sysref_lmfc) else $error("no realign after reference");
	property p_lmfc_period; lcnt == 6'(LMFC_PERIOD - 1) |-> lmfc_pulse; endproperty
	a_lmfc_period: assert property (p_lmfc_period) else $error("multiframe edge missing");
	property p_pipe_delay; dp_valid |-> $past(pclk_ce, PIPE_LEN) || $past(pclk_ce, PIPE_LEN + 1); endproperty
	a_pipe_delay: assert property (p_pipe_delay) else $error("sample out at wrong delay");
	property p_order; dp_valid |-> nout < nin; endproperty
	a_order: assert property (p_order) else $error("sample out without input");
	property p_refuse; $fell(deframe_ready) |-> $past(deframe_valid); endproperty
	a_refuse: assert property (p_refuse) else $error("space lost without a push");
endmodule
bind lat_align_top lat_align_chk #(.PIPE_LEN(PIPE_LEN)) chk (.*);

/* lat_align_pkg.sv */
// Constants, register map and timing figures for the receive latency alignment block
package lat_align_pkg;
	// Register byte addresses (printed offsets are indices)
	localparam logic [11:0] PHASE_A_IDX   = 12'h037;
	localparam logic [11:0] PHASE_B_IDX   = 12'h038;
	localparam logic [11:0] ADDR_PHASE_A  = 12'h0dc;
	localparam logic [11:0] ADDR_PHASE_B  = 12'h0e0;
	localparam logic [11:0] ADDR_CTRL     = 12'h100;
	localparam logic [11:0] ADDR_STATUS   = 12'h104;
	localparam logic [11:0] ADDR_LATENCY  = 12'h108;
	// Control field positions
	localparam int CTRL_SUBCLASS1 = 0;
	localparam int CTRL_MODE_LSB  = 1;
	localparam int CTRL_INTERP1X  = 3;
	localparam int CTRL_NCO_ONLY  = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0011;
	// Sampling modes of a lane
	typedef enum logic [1:0] {MODE_HALF, MODE_FULL, MODE_OVS, MODE_OVS2} lane_mode_t;
	// Lane rate limits in Mbps
	localparam logic [15:0] RATE_HALF_MAX = 16'h30d4; // 12500
	localparam logic [15:0] RATE_FULL_MAX = 16'h186a; // 6250
	localparam logic [15:0] RATE_OVS_MAX  = 16'h0c35; // 3125
	localparam logic [15:0] RATE_OVS2_MAX = 16'h061a; // 1562
	// Sample rate limits in MSPS
	localparam logic [15:0] CPLX_MAX_MSPS = 16'h09c4; // 2500
	localparam logic [15:0] REAL_MAX_MSPS = 16'h1388; // 5000
	// Timing figures
	localparam int PCLK_DIV        = 40;
	localparam int FIXED_LAT_MAX   = 12;
	localparam int VAR_LAT_MAX     = 2;
	localparam int IFACE_LAT       = 1;
	localparam int PIPE_DELAY      = 48;
	localparam int LMFC_DELAY      = 4;
	localparam int SYSREF_DIV      = 4;
	localparam int LMFC_PERIOD     = 32;
endpackage

/* lat_align_top.sv */
// Receive latency alignment: sample handoff, reference capture, multiframe clock and APB registers
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module lat_align_top
	import lat_align_pkg::*;
#(
	parameter int SAMPLE_W   = 32,
	parameter int FIFO_DEPTH = 8,
	parameter int PIPE_LEN   = PIPE_DELAY
) (
	input  wire logic                core_clk,    // Device clock
	input  wire logic                sys_rst,     // Sync reset, high
	input  wire logic                pclk_ce,     // Processing clock enable (lane rate / 40)
	input  wire logic                sysref_in,   // Sync reference pin
	input  wire logic [SAMPLE_W-1:0] deframe_data,// Deframed sample word
	input  wire logic                deframe_valid,// Sample present
	output logic                     deframe_ready,// FIFO space
	input  wire logic [15:0]         lane_rate_mbps,// Lane rate from link setup
	input  wire logic [15:0]         sample_msps, // Input sample rate
	output logic [SAMPLE_W-1:0]      dp_data,     // Datapath output sample
	output logic                     dp_valid,    // Output sample valid
	output logic                     lmfc_pulse,  // Multiframe clock edge
	input  wire logic                psel,        // APB select
	input  wire logic                penable,     // APB enable
	input  wire logic                pwrite,      // APB write
	input  wire logic [11:0]         paddr,       // APB address
	input  wire logic [31:0]         pwdata,      // APB write data
	output logic [31:0]              prdata,      // APB read data
	output logic                     pready,      // APB ready
	output logic                     pslverr      // APB error
);
	import lat_align_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [31:0]         ctrl_reg;
	logic                sref_s1_reg;
	logic                sref_s2_reg;
	logic                sref_q_reg;
	logic [SYSREF_DIV-2:0] sref_win_reg;
	logic [1:0]          cap_phase;
	logic [7:0]          phase_a_reg;
	logic [7:0]          phase_b_reg;
	logic [2:0]          realign_cnt_reg;
	logic                realign_reg;
	logic [5:0]          lmfc_cnt_reg;
	logic                rate_err_reg;
	logic                smp_err_reg;
	logic [SAMPLE_W-1:0] ifc_data_reg;
	logic                ifc_valid_reg;
	logic [SAMPLE_W:0]   pipe_reg [PIPE_LEN];
	logic [SAMPLE_W-1:0] fifo_data;
	logic                fifo_valid;
	logic                fifo_pop;
	logic                sref_tick;
	logic                sref_edge;
	logic [15:0]         rate_max;
	logic [15:0]         smp_max;
	logic                apb_acc;
	logic                addr_ok;
	logic [31:0]         rd_mux;
	lane_mode_t          mode;

	assign mode = lane_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);

	////////////////////////////////////////////////////////////////////////////
	// Deframed sample buffer
	lat_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.in_data  (deframe_data),
		.in_valid (deframe_valid),
		.in_ready (deframe_ready),
		.out_data (fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	// One word per processing-clock cycle leaves the buffer
	assign fifo_pop = pclk_ce;

	// Interface stage: one processing-clock cycle into the datapath
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ifc_data_reg  <= '0;
			ifc_valid_reg <= 1'b0;
		end else if (pclk_ce) begin
			ifc_data_reg  <= fifo_data;
			ifc_valid_reg <= fifo_valid;
		end
	end

	// Datapath pipeline of fixed device-clock depth
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < PIPE_LEN; i++)
				pipe_reg[i] <= '0;
		end else begin
			pipe_reg[0] <= {ifc_valid_reg && pclk_ce, ifc_data_reg};
			for (int i = 1; i < PIPE_LEN; i++)
				pipe_reg[i] <= pipe_reg[i-1];
		end
	end

	assign dp_data  = pipe_reg[PIPE_LEN-1][SAMPLE_W-1:0];
	assign dp_valid = pipe_reg[PIPE_LEN-1][SAMPLE_W];

	////////////////////////////////////////////////////////////////////////////
	// Reference input synchroniser
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sref_s1_reg <= 1'b0;
			sref_s2_reg <= 1'b0;
		end else begin
			sref_s1_reg <= sysref_in;
			sref_s2_reg <= sref_s1_reg;
		end
	end

	// Quarter-rate sampling divider
	lat_pclk_div #(.DIV(SYSREF_DIV)) u_sref_div (
		.core_clk(core_clk),
		.sys_rst (sys_rst),
		.clear   (1'b0),
		.tick    (sref_tick),
		.phase   ()
	);

	// Window history of per-phase samples shifted every clock, plus the quarter-rate sample
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sref_win_reg <= '0;
			sref_q_reg   <= 1'b0;
		end else begin
			sref_win_reg <= {sref_win_reg[SYSREF_DIV-3:0], sref_s2_reg};
			if (sref_tick)
				sref_q_reg <= sref_s2_reg;
		end
	end

	// Oldest high sample in the window gives the capture phase
	always_comb begin
		cap_phase = '0;
		for (int i = 0; i < SYSREF_DIV-1; i++)
			if (sref_win_reg[i])
				cap_phase = 2'(i + 1);
	end

	assign sref_edge = sref_tick && sref_s2_reg && !sref_q_reg;

	// Capture phase readback
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			phase_a_reg <= '0;
			phase_b_reg <= '0;
		end else if (sref_edge) begin
			phase_a_reg <= {6'h00, cap_phase};
			phase_b_reg <= 8'({sref_win_reg, sref_s2_reg}); // Raw window, newest in bit 0
		end
	end

	// Realignment delay after a captured edge, subclass 1 only
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			realign_cnt_reg <= '0;
			realign_reg     <= 1'b0;
		end else begin
			realign_reg <= 1'b0;
			if (sref_edge && ctrl_reg[CTRL_SUBCLASS1])
				realign_cnt_reg <= 3'(LMFC_DELAY);
			else if (realign_cnt_reg != '0) begin
				realign_cnt_reg <= realign_cnt_reg - 3'h1;
				realign_reg     <= (realign_cnt_reg == 3'h1);
			end
		end
	end

	// Local multiframe clock counter
	always_ff @(posedge core_clk) begin
		if (sys_rst || realign_reg)
			lmfc_cnt_reg <= '0;
		else if (lmfc_cnt_reg == 6'(LMFC_PERIOD-1))
			lmfc_cnt_reg <= '0;
		else
			lmfc_cnt_reg <= lmfc_cnt_reg + 6'h01;
	end

	assign lmfc_pulse = (lmfc_cnt_reg == '0);

	////////////////////////////////////////////////////////////////////////////
	// Rate range
	always_comb begin
		case (mode)
			MODE_HALF: rate_max = RATE_HALF_MAX;
			MODE_FULL: rate_max = RATE_FULL_MAX;
			MODE_OVS:  rate_max = RATE_OVS_MAX;
			MODE_OVS2: rate_max = RATE_OVS2_MAX;
			default:   rate_max = RATE_HALF_MAX;
		endcase
		smp_max = ctrl_reg[CTRL_INTERP1X] ? REAL_MAX_MSPS : CPLX_MAX_MSPS;
	end

	// Sticky limit errors, cleared by writing a one to their status bit
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rate_err_reg <= 1'b0;
			smp_err_reg  <= 1'b0;
		end else begin
			if (lane_rate_mbps > rate_max)
				rate_err_reg <= 1'b1;
			else if (apb_acc && pwrite && paddr == ADDR_STATUS && pwdata[0])
				rate_err_reg <= 1'b0;
			if (sample_msps > smp_max)
				smp_err_reg <= 1'b1;
			else if (apb_acc && pwrite && paddr == ADDR_STATUS && pwdata[1])
				smp_err_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, error on unmapped addresses
	assign apb_acc = psel && penable;
	assign pready  = 1'b1;
	assign addr_ok = (paddr == ADDR_PHASE_A) || (paddr == ADDR_PHASE_B) || (paddr == ADDR_CTRL)
	              || (paddr == ADDR_STATUS) || (paddr == ADDR_LATENCY);
	assign pslverr = apb_acc && !addr_ok;

	// Control register write
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			ctrl_reg <= CTRL_RESET;
		else if (apb_acc && pwrite && paddr == ADDR_CTRL)
			ctrl_reg <= {27'h0, pwdata[4:0]};
	end

	// Read mux
	always_comb begin
		case (paddr)
			ADDR_PHASE_A: rd_mux = {24'h0, phase_a_reg};
			ADDR_PHASE_B: rd_mux = {24'h0, phase_b_reg};
			ADDR_CTRL:    rd_mux = ctrl_reg;
			ADDR_STATUS:  rd_mux = {30'h0, smp_err_reg, rate_err_reg};
			ADDR_LATENCY: rd_mux = {8'(PIPE_LEN), 8'(IFACE_LAT), 8'(VAR_LAT_MAX), 8'(FIXED_LAT_MAX)};
			default:      rd_mux = 32'h0;
		endcase
	end

	// Read data register
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
			prdata <= rd_mux;
	end
endmodule

/* lat_fifo.sv */
// Parameterised valid/ready FIFO for deframed samples
`timescale 1ns/1ps
module lat_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             core_clk, // Clock
	input  wire logic             sys_rst,  // Sync reset
	input  wire logic [WIDTH-1:0] in_data,  // Write data
	input  wire logic             in_valid, // Write request
	output logic                  in_ready, // Space left
	output logic      [WIDTH-1:0] out_data, // Head word
	output logic                  out_valid,// Not empty
	input  wire logic             out_ready // Drain
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// Handshakes
	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_reg];

	// Storage
	always_ff @(posedge core_clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	// Pointers and fill count
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

/* lat_pclk_div.sv */
// Divider making one-cycle enable pulses at a fixed fraction of the clock
`timescale 1ns/1ps
module lat_pclk_div #(
	parameter int DIV = 40
) (
	input  wire logic core_clk, // Clock
	input  wire logic sys_rst,  // Sync reset
	input  wire logic clear,    // Restart the count
	output logic      tick,     // One-cycle pulse
	output logic [7:0] phase    // Current count
);
	logic [7:0] cnt_reg;

	// Free-running count, restarted by clear
	always_ff @(posedge core_clk) begin
		if (sys_rst || clear)
			cnt_reg <= '0;
		else if (cnt_reg == 8'(DIV-1))
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_reg + 8'h01;
	end

	assign tick  = (cnt_reg == 8'(DIV-1));
	assign phase = cnt_reg;
endmodule

/* lat_tx_model.sv */
// Behavioural lane transmitter feeding the alignment block
`timescale 1ns/1ps
module lat_tx_model #(
	parameter int PDIV = 4
) (
	input  wire logic        core_clk,      // Device clock
	input  wire logic        sys_rst,       // Sync reset
	input  wire logic        send,          // Offer words
	input  wire logic [31:0] din,           // Next word
	input  wire logic        sref_go,       // Start reference
	input  wire logic        deframe_ready, // Receiver space
	output logic             pclk_ce,       // Processing enable
	output logic             sysref_in,     // Reference pin
	output logic [31:0]      deframe_data,  // Lane word
	output logic             deframe_valid  // Word offered
);
	logic [7:0] pcnt;
	logic [3:0] scnt;
	// Processing enable as a fixed fraction of the clock
	always_ff @(posedge core_clk) begin
		pcnt <= (sys_rst || pcnt == 8'(PDIV - 1)) ? 8'h00 : pcnt + 8'h01;
		pclk_ce <= !sys_rst && pcnt == 8'(PDIV - 1);
	end
	// Reference held long enough for the quarter-rate sampler
	always_ff @(posedge core_clk) begin
		scnt <= sys_rst ? 4'h0 : sref_go ? 4'hc : scnt - {3'h0, scnt != 4'h0};
		sysref_in <= !sys_rst && scnt != 4'h0;
	end
	// Word held until taken; an idle lane shows inverted data
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			deframe_valid <= 1'b0;
			deframe_data <= 32'h0;
		end else if (!deframe_valid || deframe_ready) begin
			deframe_valid <= send;
			deframe_data <= send ? din : ~deframe_data;
		end
	end
endmodule

/* tb.sv */
// Self-checking bench for the latency alignment block
`timescale 1ns/1ps
module tb;
	import lat_align_pkg::*;
	logic        core_clk, sys_rst, pclk_ce, sysref_in, deframe_valid, deframe_ready, dp_valid, lmfc_pulse;
	logic        psel, penable, pwrite, pready, pslverr, send, sref_go, saw_full, e;
	logic [11:0] paddr;
	logic [15:0] lane_rate_mbps, sample_msps, v, lim;
	logic [31:0] deframe_data, dp_data, pwdata, prdata, din, r, seed, mask;
	logic [31:0] q[$];
	logic [41:0] hist;
	logic [1:0]  pa;
	int          err_total, compares, cyc;
	lat_align_top dut (.*);
	lat_tx_model tx (.*);
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] rmax(input logic [1:0] m);
		return m == 0 ? RATE_HALF_MAX : m == 1 ? RATE_FULL_MAX : m == 2 ? RATE_OVS_MAX : RATE_OVS2_MAX;
	endfunction
	task automatic chk(input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// One APB transfer, then an idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	// Hold rates, clear flags, read them back
	task automatic stat(input logic [15:0] rate, msps, input logic [1:0] exp);
		lane_rate_mbps <= rate;
		sample_msps <= msps;
		repeat (3) @(posedge core_clk);
		apb(1'b1, ADDR_STATUS, 32'h3, r, e);
		apb(1'b0, ADDR_STATUS, 32'h0, r, e);
		chk(r & 32'h3, {30'h0, exp});
	endtask
	// Sample order, fill tracking and hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (deframe_valid && deframe_ready)
			q.push_back(deframe_data);
		if (deframe_valid && !deframe_ready)
			saw_full = 1'b1;
		if (dp_valid === 1'b1)
			chk(dp_data, q.pop_front());
		if (cyc > 5000) begin
			err_total++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{sys_rst, psel, penable, pwrite, send, sref_go, saw_full} = 7'h40;
		{paddr, pwdata, din, mask} = '0;
		seed = 32'h4971f985;
		lane_rate_mbps = 16'h0100;
		sample_msps = 16'h0001;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		apb(1'b0, ADDR_CTRL, 32'h0, r, e);
		chk(r, CTRL_RESET);
		apb(1'b0, 12'h200, 32'h0, r, e);
		chk({r[31:1], e}, 32'h1);
		$display("test registers done");
		for (int j = 0; j < 6; j++) begin
			apb(1'b1, ADDR_CTRL, 32'h11 | 32'(j < 4 ? j << 1 : (j - 4) << 3), r, e);
			lim = j < 4 ? rmax(2'(j)) : j == 4 ? CPLX_MAX_MSPS : REAL_MAX_MSPS;
			for (int k = 0; k < 3; k++) begin
				v = k == 0 ? lim : k == 1 ? lim + 16'h1 : 16'(xs()) & 16'h3fff;
				if (j < 4)
					stat(v, 16'h0001, {1'b0, v > lim});
				else
					stat(16'h0100, v, {v > lim, 1'b0});
			end
		end
		$display("test rate limits done");
		send <= 1'b1;
		repeat (60) begin
			din <= xs();
			@(posedge core_clk);
		end
		send <= 1'b0;
		repeat (250) @(posedge core_clk);
		chk({31'h0, saw_full}, 32'h1);
		chk(32'(q.size()), 32'h0);
		$display("test sample stream done");
		for (int k = 0; k < 4; k++) begin
			sref_go <= 1'b1;
			@(posedge core_clk);
			sref_go <= 1'b0;
			for (int n = 0; n < 42; n++) begin
				@(posedge core_clk);
				hist[n] = lmfc_pulse;
			end
			apb(1'b0, ADDR_PHASE_A, 32'h0, r, e);
			chk(r & 32'hfffffffc, 32'h0);
			mask[r[1:0]] = 1'b1;
			pa = r[1:0];
			chk({31'h0, hist[9 + pa]}, 32'h1);
			apb(1'b0, ADDR_PHASE_B, 32'h0, r, e);
			chk(r, (32'h2 << pa) - 32'h1);
		end
		chk(mask, 32'hf);
		$display("test reference phase done");
		close_out();
	end
endmodule
